/* File: hdl/stx_datapath.sv */
`timescale 1ns/10ps

module stx_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  // Extra pointer bit tells full from empty
  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Storage has no reset, only the pointers need one
  always_ff @(posedge aclk) begin
    if (ce && in_valid && !full) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else if (ce) begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule : stx_fifo

module stx_datapath
  import stx_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  clk_en,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Transmit parallel side
  input  wire logic [STX_DATA_W-1:0] tx_word,
  input  wire logic                  tx_word_valid,
  output logic                       tx_word_ready,
  output logic                       tx_parallel_clock_out,
  // Serial line, one bit per aclk
  output logic                       tx_serial,
  output logic                       tx_oob_idle,
  input  wire logic                  rx_serial,
  input  wire logic                  rx_oob_in,
  // Receive parallel side
  input  wire logic                  rx_user_word_clock,
  output logic [STX_DATA_W-1:0]      rx_word,
  output logic                       rx_word_valid,
  output logic                       rx_oob_seen,
  output logic                       rx_low_power_equalizer_mode,
  output logic                       tx_locked,
  output logic                       rx_locked
);

  logic [31:0]            tx_ctrl;
  logic [31:0]            rx_ctrl;
  stx_cfg_t               tcfg;
  stx_cfg_t               rcfg;
  stx_state_t             tx_st;
  stx_state_t             rx_st;
  logic [7:0]             tx_lock_cnt;
  logic [7:0]             rx_lock_cnt;
  logic [7:0]             aw_q;
  logic                   aw_have;
  logic [31:0]            w_q;
  logic [3:0]             ws_q;
  logic                   w_have;
  logic [5:0]             tx_bit;
  logic [5:0]             rx_bit;
  logic [5:0]             tx_len;
  logic [5:0]             rx_len;
  logic [STX_DATA_W-1:0]  tx_shift;
  logic [STX_DATA_W-1:0]  rx_shift;
  logic                   f_valid;
  logic                   f_ready;
  logic [STX_DATA_W-1:0]  f_data;
  logic                   src_valid;
  logic [STX_DATA_W-1:0]  src_data;
  logic                   load;
  logic                   disp;
  logic [STX_DATA_W-1:0]  rx_hold;
  logic                   rx_hold_new;
  logic                   user_clk_q;
  logic                   rx_err;
  logic [STX_DATA_W-1:0]  tx_coded;

  // Configuration views of the control words
  assign tcfg = '{tx_ctrl[STX_F_EN], tx_ctrl[STX_F_WID+:2], tx_ctrl[STX_F_ENC+:2],
                  tx_ctrl[STX_F_FIFO], tx_ctrl[STX_F_OOB], 1'b0, tx_ctrl[STX_F_MULT+:5]};
  assign rcfg = '{rx_ctrl[STX_F_EN], rx_ctrl[STX_F_WID+:2], rx_ctrl[STX_F_ENC+:2],
                  1'b0, 1'b0, rx_ctrl[STX_F_LOW_EQ], rx_ctrl[STX_F_MULT+:5]};

  // Bits per word for a width code
  function automatic logic [5:0] stx_len(input logic [1:0] w);
    unique case (w)
      STX_W16: stx_len = 6'h10;
      STX_W20: stx_len = 6'h14;
      STX_W32: stx_len = 6'h20;
      STX_W40: stx_len = 6'h28;
    endcase
  endfunction : stx_len

  assign tx_len = stx_len(tcfg.width);
  assign rx_len = stx_len(rcfg.width);

  // Write channels are taken in either order, response follows both
  // Readys drop while frozen, or a handshake would be lost
  assign s_axi_awready = clk_en && !aw_have && !s_axi_bvalid;
  assign s_axi_wready  = clk_en && !w_have && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h00000000;
      ws_q    <= 4'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q    <= s_axi_awaddr;
        aw_have <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q    <= s_axi_wdata;
        ws_q   <= s_axi_wstrb;
        w_have <= 1'b1;
      end
      if (aw_have && w_have) begin
        aw_have <= 1'b0;
        w_have  <= 1'b0;
      end
    end
  end

  // Merge one write under byte strobes
  function automatic logic [31:0] stx_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] st);
    stx_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        stx_merge[i*8+:8] = nw[i*8+:8];
      end
    end
  endfunction : stx_merge

  // Control registers: each direction has its own word, written live or at reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ctrl      <= STX_CTRL_RST;
      rx_ctrl      <= STX_CTRL_RST;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (clk_en) begin
      if (aw_have && w_have) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'h0;
        unique case (aw_q[7:2])
          STX_REG_TX_CTRL[7:2]: tx_ctrl <= stx_merge(tx_ctrl, w_q, ws_q);
          STX_REG_RX_CTRL[7:2]: rx_ctrl <= stx_merge(rx_ctrl, w_q, ws_q);
          default: s_axi_bresp <= 2'h2;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel; unmapped addresses answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= 2'h0;
    end else if (clk_en) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        unique case (s_axi_araddr[7:2])
          STX_REG_TX_CTRL[7:2]: s_axi_rdata <= tx_ctrl;
          STX_REG_RX_CTRL[7:2]: s_axi_rdata <= rx_ctrl;
          STX_REG_STATUS[7:2]:  s_axi_rdata <= {27'h0, rx_err, rx_oob_seen, !f_ready,
                                                rx_locked, tx_locked};
          STX_REG_RX_WORD[7:2]: s_axi_rdata <= rx_hold[31:0];
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Lock sequencers; settling takes STX_LOCK_CYCLES whatever the factor; a factor outside 1 to 25 never locks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_st       <= STX_ST_RESET;
      tx_lock_cnt <= 8'h00;
    end else if (clk_en) begin
      unique case (tx_st)
        STX_ST_RESET: if (tcfg.enable && tcfg.mult != 5'h0 && tcfg.mult <= STX_MULT_MAX) begin
          tx_st       <= STX_ST_LOCKING;
          tx_lock_cnt <= STX_LOCK_CYCLES;
        end
        STX_ST_LOCKING: begin
          if (tx_lock_cnt == 8'h00) begin
            tx_st <= STX_ST_RUN;
          end else begin
            tx_lock_cnt <= tx_lock_cnt - 8'h01;
          end
        end
        STX_ST_RUN: if (!tcfg.enable) begin
          tx_st <= STX_ST_RESET;
        end
        default: tx_st <= STX_ST_RESET;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_st       <= STX_ST_RESET;
      rx_lock_cnt <= 8'h00;
    end else if (clk_en) begin
      unique case (rx_st)
        STX_ST_RESET: if (rcfg.enable && rcfg.mult != 5'h0 && rcfg.mult <= STX_MULT_MAX) begin
          rx_st       <= STX_ST_LOCKING;
          rx_lock_cnt <= STX_LOCK_CYCLES;
        end
        STX_ST_LOCKING: begin
          if (rx_lock_cnt == 8'h00) begin
            rx_st <= STX_ST_RUN;
          end else begin
            rx_lock_cnt <= rx_lock_cnt - 8'h01;
          end
        end
        STX_ST_RUN: if (!rcfg.enable) begin
          rx_st <= STX_ST_RESET;
        end
        default: rx_st <= STX_ST_RESET;
      endcase
    end
  end

  assign tx_locked = (tx_st == STX_ST_RUN);
  assign rx_locked = (rx_st == STX_ST_RUN);

  stx_fifo #(
    .WIDTH (STX_DATA_W),
    .DEPTH (STX_FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (clk_en),
    .in_valid  (tx_word_valid && tcfg.fifo_en && tx_locked),
    .in_ready  (f_ready),
    .in_data   (tx_word),
    .out_valid (f_valid),
    .out_ready (load && tcfg.fifo_en),
    .out_data  (f_data)
  );

  // FIFO or direct path into the shifter
  assign src_valid     = tcfg.fifo_en ? f_valid : tx_word_valid;
  assign src_data      = tcfg.fifo_en ? f_data : tx_word;
  assign load          = tx_locked && (tx_bit == 6'h0) && !tcfg.oob;
  assign tx_word_ready = clk_en && tx_locked && (tcfg.fifo_en ? f_ready : load);

  // Coding: the 8B/10B stand-in inverts by running disparity, the block codes overwrite the lowest bits with a sync
  // header; the data lanes carry the already-framed symbol bits the user supplies.
  function automatic logic [STX_DATA_W-1:0] stx_encode(input logic [STX_DATA_W-1:0] d,
                                                       input logic [1:0] e, input logic rd);
    unique case (e)
      STX_ENC_NONE:   stx_encode = d;
      STX_ENC_8B10B:  stx_encode = rd ? ~d : d;
      STX_ENC_64B66B: stx_encode = {d[STX_DATA_W-1:2], 2'b01};
      STX_ENC_64B67B: stx_encode = {d[STX_DATA_W-1:3], 3'b101};
    endcase
  endfunction : stx_encode

  assign tx_coded = stx_encode(src_data, tcfg.enc, disp);

  // Serializer: one NRZ bit per cycle, LSB first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_bit                <= 6'h0;
      tx_shift              <= '0;
      tx_serial             <= 1'b0;
      tx_parallel_clock_out <= 1'b0;
      disp                  <= 1'b0;
    end else if (clk_en) begin
      if (!tx_locked) begin
        tx_bit    <= 6'h0;
        tx_serial <= 1'b0;
      end else begin
        if (tx_bit == 6'h0) begin
          tx_shift  <= src_valid ? tx_coded >> 1 : '0;
          tx_serial <= src_valid ? tx_coded[0] : disp;
          if (src_valid && tcfg.enc == STX_ENC_8B10B) begin
            disp <= ~disp;
          end
        end else begin
          tx_serial <= tx_shift[0];
          tx_shift  <= tx_shift >> 1;
        end
        tx_bit <= (tx_bit == tx_len - 6'h1) ? 6'h0 : tx_bit + 6'h1;
      end
      // Word clock high for the first half of each word, so it divides by the width
      tx_parallel_clock_out <= tx_locked && (tx_bit < (tx_len >> 1));
    end
  end

  // Out-of-band: line held idle while high speed is off
  assign tx_oob_idle = tcfg.oob || !tx_locked;

  // Deserializer, bit timing taken from aclk, one sampled bit per cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_bit      <= 6'h0;
      rx_shift    <= '0;
      rx_hold     <= '0;
      rx_hold_new <= 1'b0;
      rx_err      <= 1'b0;
    end else if (clk_en) begin
      if (!rx_locked) begin
        rx_bit      <= 6'h0;
        rx_hold_new <= 1'b0;
      end else begin
        rx_shift <= {rx_serial, rx_shift[STX_DATA_W-1:1]};
        if (rx_bit == rx_len - 6'h1) begin
          rx_bit      <= 6'h0;
          rx_hold     <= {rx_serial, rx_shift[STX_DATA_W-1:1]} >> (STX_DATA_W - rx_len);
          rx_hold_new <= 1'b1;
          rx_err      <= rx_err || rx_hold_new; // Overrun if last word never handed over
        end else begin
          rx_bit <= rx_bit + 6'h1;
          if (rx_hold_new && rx_user_word_clock && !user_clk_q) begin
            rx_hold_new <= 1'b0;
          end
        end
      end
    end
  end

  // Hand-over on rising edge of the user word clock strobe, sampled in aclk
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      user_clk_q    <= 1'b0;
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
      rx_oob_seen   <= 1'b0;
    end else if (clk_en) begin
      user_clk_q    <= rx_user_word_clock;
      rx_word_valid <= 1'b0;
      if (rx_locked && rx_hold_new && rx_user_word_clock && !user_clk_q) begin
        rx_word       <= rx_hold;
        rx_word_valid <= 1'b1;
      end
      rx_oob_seen <= !rx_locked && rx_oob_in;
    end
  end

  // Only the mode select exists here; the analog paths are outside this block
  assign rx_low_power_equalizer_mode = rcfg.low_eq;

  // one serial bit per aclk; real line rate is set by the analog clocking
  // and sub-native rates are expected from fabric oversampling upstream.

endmodule : stx_datapath

/* File: hdl/stx_pkg.sv */
package stx_pkg;

  // Word widths selectable on both directions
  localparam logic [1:0] STX_W16 = 2'h0;
  localparam logic [1:0] STX_W20 = 2'h1;
  localparam logic [1:0] STX_W32 = 2'h2;
  localparam logic [1:0] STX_W40 = 2'h3;

  // Line encodings
  localparam logic [1:0] STX_ENC_NONE = 2'h0;
  localparam logic [1:0] STX_ENC_8B10B = 2'h1;
  localparam logic [1:0] STX_ENC_64B66B = 2'h2;
  localparam logic [1:0] STX_ENC_64B67B = 2'h3;

  localparam int STX_DATA_W = 40;
  localparam int STX_FIFO_DEPTH = 16;
  localparam logic [4:0] STX_MULT_MAX = 5'h19;
  localparam logic [4:0] STX_MULT_RST = 5'h0A;
  localparam logic [7:0] STX_LOCK_CYCLES = 8'h20;

  // Register byte offsets
  localparam logic [7:0] STX_REG_TX_CTRL = 8'h00;
  localparam logic [7:0] STX_REG_RX_CTRL = 8'h04;
  localparam logic [7:0] STX_REG_STATUS = 8'h08;
  localparam logic [7:0] STX_REG_RX_WORD = 8'h0C;
  localparam logic [7:0] STX_REG_TX_WORD = 8'h10;

  // Control field positions
  localparam int STX_F_EN = 0;
  localparam int STX_F_WID = 1;
  localparam int STX_F_ENC = 3;
  localparam int STX_F_FIFO = 5;
  localparam int STX_F_OOB = 6;
  localparam int STX_F_LOW_EQ = 7;
  localparam int STX_F_MULT = 8;
  localparam logic [31:0] STX_CTRL_RST = 32'h00000A00;

  typedef struct packed {
    logic       enable;
    logic [1:0] width;
    logic [1:0] enc;
    logic       fifo_en;
    logic       oob;
    logic       low_eq;
    logic [4:0] mult;
  } stx_cfg_t;

  typedef enum logic [1:0] {
    STX_ST_RESET = 2'b00,
    STX_ST_LOCKING = 2'b01,
    STX_ST_RUN = 2'b11
  } stx_state_t;

endpackage : stx_pkg

/* File: verif/stx_datapath_bench.sv */
`timescale 1ns/10ps
module stx_datapath_bench;
  import stx_pkg::*;
  logic        aclk, aresetn, awv, wv, bv, brdy, arv, rv, rrdy, awrdy, wrdy, arrdy, ce;
  logic        txv, txr, pclk, txs, oobi, rxs, rxo, uclk, rxv, seen, leq, txl, rxl, oobc;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rd, rdat;
  logic [1:0]  br, rr, wresp, rresp;
  logic [39:0] txw, rxw, heard;
  int          n_mismatch, samples_checked;

  stx_datapath i_dut (
    .aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arrdy),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .tx_word(txw), .tx_word_valid(txv), .tx_word_ready(txr),
    .tx_parallel_clock_out(pclk), .tx_serial(txs), .tx_oob_idle(oobi),
    .rx_serial(rxs), .rx_oob_in(rxo), .rx_user_word_clock(uclk),
    .rx_word(rxw), .rx_word_valid(rxv), .rx_oob_seen(seen),
    .rx_low_power_equalizer_mode(leq), .tx_locked(txl), .rx_locked(rxl)
  );

  stx_far_end i_far (
    .aclk(aclk), .aresetn(aresetn), .tx_serial(txs), .tx_oob_idle(oobi),
    .oob_cmd(oobc), .rx_serial(rxs), .rx_oob_in(rxo), .heard(heard)
  );

  // 25 MHz system clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task test_done;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done

  task chk(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // A used-up wait bound ends the run at once
  task tmo(input int n);
    if (n >= 100) begin
      chk(40'(n), 40'h0000000000);
      test_done();
    end
  endtask : tmo

  // Address and data offered together; the edge first keeps back-to-back calls apart
  task axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!(bv && brdy) && n < 100);
    wresp = br;
    brdy <= 1'b0;
    tmo(n);
  endtask : axw

  task axr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arv && arrdy) arv <= 1'b0;
    end while (!(rv && rrdy) && n < 100);
    rdat = rd;
    rresp = rr;
    rrdy <= 1'b0;
    tmo(n);
  endtask : axr

  task cfg(input logic [7:0] a, input logic [31:0] d);
    axw(a, d);
    chk(wresp, 2'h0);
  endtask : cfg

  // Lock is expected some 34 cycles after the enable lands
  task lock_wait(input logic rx);
    int n;
    n = 0;
    while (!(rx ? rxl : txl) && n < 100) begin
      @(posedge aclk);
      n++;
    end
    tmo(n);
    chk(n >= 28 && n <= 36, 1'b1);
  endtask : lock_wait

  task rise_gap(output int n);
    logic p;
    n = 0;
    do begin
      p = pclk;
      @(posedge aclk);
      n++;
    end while (!(pclk && !p) && n < 100);
    tmo(n);
  endtask : rise_gap

  task sc_regs;
    logic [1:0] e;
    axr(STX_REG_TX_CTRL);
    chk(rdat, STX_CTRL_RST);
    axr(STX_REG_RX_CTRL);
    chk(rdat, STX_CTRL_RST);
    axr(STX_REG_STATUS);
    chk(rdat, 32'h00000000);
    axr(STX_REG_TX_WORD);
    chk({rresp, rdat}, {2'h2, 32'h00000000});
    axw(STX_REG_TX_WORD, 32'h00000001);
    chk(wresp, 2'h2);
    for (int i = 0; i < 4; i++) begin
      e = i[1:0];
      cfg(STX_REG_TX_CTRL, {19'h00000, 5'h0A, 3'h0, e, e, 1'b0});
      axr(STX_REG_TX_CTRL);
      chk(rdat, {19'h00000, 5'h0A, 3'h0, e, e, 1'b0});
    end
    cfg(STX_REG_TX_CTRL, STX_CTRL_RST);
  endtask : sc_regs

  // Out-of-range multipliers must never lock; the top legal one must
  task sc_mult;
    logic [4:0] m [3];
    m = '{5'h1A, 5'h00, STX_MULT_MAX};
    for (int i = 0; i < 3; i++) begin
      cfg(STX_REG_TX_CTRL, {19'h00000, m[i], 8'h01});
      if (i < 2) begin
        repeat (45) @(posedge aclk);
        chk(txl, 1'b0);
      end else lock_wait(1'b0);
    end
    cfg(STX_REG_TX_CTRL, STX_CTRL_RST);
  endtask : sc_mult

  task sc_oob;
    oobc <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(seen, 1'b1);
    oobc <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(seen, 1'b0);
    cfg(STX_REG_TX_CTRL, 32'h00000A41);
    repeat (40) @(posedge aclk);
    chk({oobi, txr}, 2'b10);
    cfg(STX_REG_TX_CTRL, STX_CTRL_RST);
  endtask : sc_oob

  task sc_tx(input int wi);
    int n, w;
    w = (wi == 0) ? 16 : (wi == 1) ? 20 : (wi == 2) ? 32 : 40;
    // Coding follows the width index, so every code goes out once
    cfg(STX_REG_TX_CTRL, 32'h00000A01 | (32'(wi) << 1) | (32'(wi) << 3));
    chk(txr, 1'b0);
    lock_wait(1'b0);
    chk(rxl, 1'b0);
    rise_gap(n);
    rise_gap(n);
    chk(40'(n), 40'(w));
    txw <= 40'hC3A5F00F96;
    txv <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!txr && n < 100);
    txv <= 1'b0;
    tmo(n);
    repeat (w) @(posedge aclk);
    #1;
    chk(heard >> (40 - w), (40'hC3A5F00F96 & ((40'h1 << w) - 1)) ^ ((wi >= 2) ? 40'h3 : 40'h0));
    cfg(STX_REG_TX_CTRL, STX_CTRL_RST);
  endtask : sc_tx

  // Far end sends alternating bits, so any word phase reads 5555 or AAAA
  task sc_rx;
    int n;
    cfg(STX_REG_RX_CTRL, 32'h00000A01);
    // A low clock enable must freeze the lock count
    ce <= 1'b0;
    repeat (50) @(posedge aclk);
    chk(rxl, 1'b0);
    ce <= 1'b1;
    lock_wait(1'b1);
    repeat (40) @(posedge aclk);
    axr(STX_REG_STATUS);
    chk({rdat[4], rdat[1]}, 2'b11);
    uclk <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!rxv && n < 100);
    tmo(n);
    chk(rxw[39:16], 24'h000000);
    chk(rxw[15:0] == 16'h5555 || rxw[15:0] == 16'hAAAA, 1'b1);
    uclk <= 1'b0;
    cfg(STX_REG_RX_CTRL, 32'h00000A81);
    chk(leq, 1'b1);
    cfg(STX_REG_RX_CTRL, STX_CTRL_RST);
    chk(leq, 1'b0);
  endtask : sc_rx

  // Fill at one word a cycle against a drain of one word per 40 cycles
  task sc_fifo;
    int n, k;
    cfg(STX_REG_TX_CTRL, 32'h00000A27);
    lock_wait(1'b0);
    txw <= 40'h0000000000;
    txv <= 1'b1;
    n = 0;
    k = 0;
    do begin
      @(posedge aclk);
      n++;
      if (txr) k++;
      if (txr) txw <= 40'(k);
    end while ((txr || k == 0) && n < 100);
    txv <= 1'b0;
    tmo(n);
    chk(k >= 16 && k <= 18, 1'b1);
    axr(STX_REG_STATUS);
    chk(rdat[2], 1'b1);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!txr && n < 100);
    tmo(n);
    chk(n <= 45, 1'b1);
    repeat (720) @(posedge aclk);
    axr(STX_REG_STATUS);
    chk(rdat[2], 1'b0);
    cfg(STX_REG_TX_CTRL, STX_CTRL_RST);
  endtask : sc_fifo

  // Main sequence
  initial begin
    n_mismatch = 0;
    samples_checked = 0;
    {aresetn, awv, wv, brdy, arv, rrdy, txv, uclk, oobc} = 9'h000;
    ce = 1'b1;
    {awa, ara, wd, txw} = 88'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    sc_regs();
    sc_mult();
    sc_oob();
    for (int i = 0; i < 4; i++) sc_tx(i);
    sc_rx();
    sc_fifo();
    test_done();
  end
endmodule : stx_datapath_bench

/* File: verif/stx_datapath_properties.sv */
`timescale 1ns/10ps
module stx_datapath_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        clk_en,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        tx_word_ready,
  input wire logic        tx_oob_idle,
  input wire logic        tx_locked,
  input wire logic        rx_locked,
  input wire logic        rx_oob_in,
  input wire logic        rx_oob_seen,
  input wire logic        rx_user_word_clock,
  input wire logic        rx_word_valid
);
  logic oob_cause;

  // Cause of the out-of-band flag, one cycle before the flag shows it
  assign oob_cause = rx_oob_in && !rx_locked;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_ready_lock;
    !tx_locked |-> !tx_word_ready;
  endproperty
  a_ready_lock: assert property (p_ready_lock)
    else $error("transmit word taken before lock");
  property p_idle_lock;
    !tx_locked |-> tx_oob_idle;
  endproperty
  a_idle_lock: assert property (p_idle_lock)
    else $error("line not idle while unlocked");
  property p_rx_lock;
    rx_word_valid |-> $past(rx_locked);
  endproperty
  a_rx_lock: assert property (p_rx_lock)
    else $error("receive word delivered before lock");
  // A word goes out only on a fresh rise of the user strobe, as a single pulse
  property p_hand_over;
    rx_word_valid |-> $past(rx_user_word_clock) && !$past(rx_user_word_clock, 2)
      ##1 !rx_word_valid;
  endproperty
  a_hand_over: assert property (p_hand_over)
    else $error("receive word not tied to user strobe");
  property p_oob_seen;
    $past(aresetn) && $past(clk_en) |-> rx_oob_seen == $past(oob_cause);
  endproperty
  a_oob_seen: assert property (p_oob_seen)
    else $error("out-of-band flag wrong");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped early");
  property p_r_next;
    s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid;
  endproperty
  a_r_next: assert property (p_r_next)
    else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed while waiting");
endmodule : stx_datapath_properties

bind stx_datapath stx_datapath_properties i_props (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .tx_word_ready(tx_word_ready), .tx_oob_idle(tx_oob_idle), .tx_locked(tx_locked),
  .rx_locked(rx_locked), .rx_oob_in(rx_oob_in), .rx_oob_seen(rx_oob_seen),
  .rx_user_word_clock(rx_user_word_clock), .rx_word_valid(rx_word_valid)
);

/* File: verif/stx_far_end.sv */
`timescale 1ns/10ps
module stx_far_end (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        tx_serial,
  input  wire logic        tx_oob_idle,
  input  wire logic        oob_cmd,
  output logic             rx_serial,
  output logic             rx_oob_in,
  output logic [39:0]      heard
);
  // Toggling NRZ stream carries its own timing, no clock goes with it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_serial <= 1'b0;
    end else begin
      rx_serial <= ~rx_serial;
    end
  end

  // Line bits land at the top, so the first bit ends lowest; idle line is ignored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      heard <= 40'h0000000000;
    end else if (!tx_oob_idle) begin
      heard <= {tx_serial, heard[39:1]};
    end
  end

  // Low-speed signalling only on command, alongside the toggling stream, which never stops
  assign rx_oob_in = oob_cmd;
endmodule : stx_far_end
